// file: inc/hbc_pkg.sv
package hbc_pkg;

	// Register indices; byte address on the bus is four times the index
	localparam logic [7:0] IDX_BASE_CLASS = 8'h0b;
	localparam logic [7:0] IDX_LATENCY_STUB = 8'h0d;
	localparam logic [7:0] IDX_HEADER_TYPE = 8'h0e;
	localparam logic [7:0] IDX_SUBSYS_VENDOR = 8'h2c;
	localparam logic [7:0] IDX_SUBSYS = 8'h2e;
	localparam logic [7:0] IDX_CAP_POINTER = 8'h34;
	localparam logic [7:0] IDX_BRIDGE_CONFIG = 8'h50;

	// Fixed read values and reset values
	localparam logic [7:0] BASE_CLASS_VALUE = 8'h06;
	localparam logic [7:0] LATENCY_STUB_VALUE = 8'h00;
	localparam logic [7:0] HEADER_TYPE_VALUE = 8'h00;
	localparam logic [7:0] CAP_POINTER_VALUE = 8'h00;
	localparam logic [15:0] SUBSYS_VENDOR_RESET = 16'h0000;
	localparam logic [15:0] SUBSYS_RESET = 16'h0000;
	localparam logic [7:0] BRIDGE_CONFIG_RESET = 8'h60;
	localparam logic [7:0] BRIDGE_CONFIG_WMASK = 8'h5b;

	// Field positions in the bridge configuration register
	localparam int BIT_DEFER_LATENCY = 6;
	localparam int BIT_LOCAL_MEM_FREQ = 4;
	localparam int BIT_PAGE_MISS_POLICY = 3;
	localparam int BIT_D8_HOLE = 1;
	localparam int BIT_CD_HOLE = 0;

	// D segment attribute field position in the attribute map
	localparam int ATTR_D_LSB = 2;

	// Legacy D segment and its holes
	localparam logic [31:0] D_SEG_BASE = 32'h000d0000;
	localparam logic [31:0] D_SEG_TOP = 32'h000dffff;
	localparam logic [31:0] D8_HOLE_BASE = 32'h000d8000;
	localparam logic [31:0] CD_HOLE_BASE = 32'h000dc000;

	// Snoop stall clocks before a deferral is allowed
	localparam logic [4:0] SNOOP_STALL_CLOCKS = 5'h1f;

	typedef enum logic [1:0]
	{
		ATTR_ALL_HUB,
		ATTR_READ_DRAM,
		ATTR_WRITE_DRAM,
		ATTR_ALL_DRAM
	} hbc_attr_e;

	typedef struct packed
	{
		logic defer_latency_select;
		logic local_mem_freq_select;
		logic page_miss_precharge_policy;
		logic d8_hole_forward_enable;
		logic cd_hole_forward_enable;
	} hbc_cfg_s;

endpackage : hbc_pkg

// file: logic/hbc_config_regs.sv
`timescale 1ns/1ps
// Functional notes
// - Base class reads 06h always; writes do nothing.
// - Master latency field at 0Dh reads all zeros.
// - Header type at 0Eh has no storage, reads zero.
// - Subsystem vendor id resets 0000h, takes one write, then locked until reset.
// - Subsystem id resets 0000h, takes one write, then locked until reset.
// - Capability pointer at 34h reads 00h.
// - Latency bit set: defer after 31 stall clocks plus another address strobe.
// - Latency bit clear: defer at the next address strobe.
// - Bit 4 selects local memory clock, 1 is 133 MHz, 0 is 100 MHz.
// - Bit 3 set precharges all banks on page miss, clear only one bank.
// - D8 hole bit set forwards D8000h to segment top to the io hub.
// - D8 hole bit clear lets D segment attributes route that region, except the CD hole when its bit is set.
// - CD hole bit set forwards DC000h to DFFFFh to the io hub.
// - CD hole bit clear, with D8 hole bit also clear, lets D segment attributes route the CD hole.
// - Bridge configuration register resets to 60h.
// - Attribute 00 hub, 01 reads DRAM, 10 writes DRAM, 11 all DRAM.
module hbc_config_regs
(
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic PREADY,
	output logic [31:0] PRDATA,
	output logic PSLVERR,
	input wire logic [7:0] LEGACY_SEGMENT_ATTRIBUTE_MAP,
	input wire logic HOST_CYCLE_VALID,
	input wire logic HOST_CYCLE_WRITE,
	input wire logic [31:0] HOST_CYCLE_ADDR,
	output logic ROUTE_IO_HUB,
	output logic ROUTE_DRAM,
	input wire logic DEFERRABLE_PENDING,
	input wire logic SNOOP_STALL,
	input wire logic HOST_ADDRESS_STROBE,
	output logic DEFER_CYCLE,
	output logic LOCAL_MEM_FREQ_133,
	output logic PAGE_MISS_PRECHARGE_ALL
);

	logic [15:0] subsys_vendor_ff;
	logic [15:0] subsys_ff;
	logic subsys_vendor_locked_ff;
	logic subsys_locked_ff;
	logic [7:0] bridge_config_ff;
	logic [31:0] prdata_ff;
	logic pslverr_ff;
	logic [4:0] stall_count_ff;
	logic defer_ff;
	logic route_hub_ff;
	logic route_dram_ff;
	logic setup_phase;
	logic write_access;
	logic [9:0] index;
	logic index_ok;
	logic [31:0] nxt_prdata;
	logic nxt_pslverr;
	logic nxt_route_hub;
	logic nxt_route_dram;
	hbc_pkg::hbc_cfg_s cfg;
	logic sel_base_class;
	logic sel_latency_stub;
	logic sel_header_type;
	logic sel_subsys_vendor;
	logic sel_subsys;
	logic sel_cap_pointer;
	logic sel_bridge_config;
	logic reg_hit;
	logic vendor_write;
	logic subsys_write;
	logic config_write;
	logic stall_at_limit;
	logic in_d_seg;
	logic in_d8_hole;
	logic in_cd_hole;
	logic host_to_dram;

	// Merge enabled byte lanes of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] wdata,
		input logic [3:0] strb);
		logic [15:0] r;
		r = old_v;
		if (strb[0])
		begin
			r[7:0] = wdata[7:0];
		end
		if (strb[1])
		begin
			r[15:8] = wdata[15:8];
		end
		return r;
	endfunction : merge16

	// Address decode shared by the read mux and the write enables
	function automatic logic index_is(input logic [9:0] idx, input logic [7:0] want);
		logic r;
		r = (idx == {2'b00, want});
		return r;
	endfunction : index_is

	// Inclusive range test for host cycle addresses
	function automatic logic addr_in(input logic [31:0] addr, input logic [31:0] lo,
		input logic [31:0] hi);
		logic r;
		r = (addr >= lo) && (addr <= hi);
		return r;
	endfunction : addr_in

	// Attribute field decode: does a cycle of this direction go to DRAM
	function automatic logic attr_to_dram(input hbc_pkg::hbc_attr_e attr, input logic wr);
		logic r;
		r = 1'b0;
		case (attr)
			hbc_pkg::ATTR_ALL_HUB:
			begin
				r = 1'b0;
			end
			hbc_pkg::ATTR_READ_DRAM:
			begin
				r = !wr;
			end
			hbc_pkg::ATTR_WRITE_DRAM:
			begin
				r = wr;
			end
			default:
			begin
				r = 1'b1;
			end
		endcase
		return r;
	endfunction : attr_to_dram

	// Only bits under the mask take write data; the rest hold
	function automatic logic [7:0] merge_masked(input logic [7:0] old_v,
		input logic [7:0] wdata, input logic [7:0] mask);
		logic [7:0] r;
		r = (wdata & mask) | (old_v & ~mask);
		return r;
	endfunction : merge_masked

	assign setup_phase = PSEL && !PENABLE;
	// Writes commit at the access edge; zero wait states so pready is always high
	assign write_access = PSEL && PENABLE && PWRITE;
	assign index = PADDR[11:2];
	// Only word-aligned addresses map a register
	assign index_ok = (PADDR[1:0] == 2'b00);
	assign sel_base_class = index_ok && index_is(index, hbc_pkg::IDX_BASE_CLASS);
	assign sel_latency_stub = index_ok && index_is(index, hbc_pkg::IDX_LATENCY_STUB);
	assign sel_header_type = index_ok && index_is(index, hbc_pkg::IDX_HEADER_TYPE);
	assign sel_subsys_vendor = index_ok && index_is(index, hbc_pkg::IDX_SUBSYS_VENDOR);
	assign sel_subsys = index_ok && index_is(index, hbc_pkg::IDX_SUBSYS);
	assign sel_cap_pointer = index_ok && index_is(index, hbc_pkg::IDX_CAP_POINTER);
	assign sel_bridge_config = index_ok && index_is(index, hbc_pkg::IDX_BRIDGE_CONFIG);
	assign reg_hit = sel_base_class || sel_latency_stub || sel_header_type || sel_subsys_vendor
		|| sel_subsys || sel_cap_pointer || sel_bridge_config;

	// A locked id swallows the write silently, with no error response
	assign vendor_write = write_access && sel_subsys_vendor && !subsys_vendor_locked_ff;
	assign subsys_write = write_access && sel_subsys && !subsys_locked_ff;
	assign config_write = write_access && sel_bridge_config && PSTRB[0];

	// Counter saturates here, so equality means the full stall was seen
	assign stall_at_limit = (stall_count_ff == hbc_pkg::SNOOP_STALL_CLOCKS);

	assign in_d_seg = HOST_CYCLE_VALID
		&& addr_in(HOST_CYCLE_ADDR, hbc_pkg::D_SEG_BASE, hbc_pkg::D_SEG_TOP);
	assign in_d8_hole = addr_in(HOST_CYCLE_ADDR, hbc_pkg::D8_HOLE_BASE, hbc_pkg::D_SEG_TOP);
	assign in_cd_hole = addr_in(HOST_CYCLE_ADDR, hbc_pkg::CD_HOLE_BASE, hbc_pkg::D_SEG_TOP);
	assign host_to_dram = attr_to_dram(
		hbc_pkg::hbc_attr_e'(LEGACY_SEGMENT_ATTRIBUTE_MAP[hbc_pkg::ATTR_D_LSB +: 2]),
		HOST_CYCLE_WRITE);
	assign PREADY = 1'b1;
	assign PRDATA = prdata_ff;
	assign PSLVERR = pslverr_ff;

	assign cfg.defer_latency_select = bridge_config_ff[hbc_pkg::BIT_DEFER_LATENCY];
	assign cfg.local_mem_freq_select = bridge_config_ff[hbc_pkg::BIT_LOCAL_MEM_FREQ];
	assign cfg.page_miss_precharge_policy = bridge_config_ff[hbc_pkg::BIT_PAGE_MISS_POLICY];
	assign cfg.d8_hole_forward_enable = bridge_config_ff[hbc_pkg::BIT_D8_HOLE];
	assign cfg.cd_hole_forward_enable = bridge_config_ff[hbc_pkg::BIT_CD_HOLE];

	assign LOCAL_MEM_FREQ_133 = cfg.local_mem_freq_select;
	assign PAGE_MISS_PRECHARGE_ALL = cfg.page_miss_precharge_policy;
	assign DEFER_CYCLE = defer_ff;
	assign ROUTE_IO_HUB = route_hub_ff;
	assign ROUTE_DRAM = route_dram_ff;

	// Read data is prepared in the setup cycle so it is stable in the access phase
	always_comb
	begin
		nxt_prdata = 32'h00000000;
		nxt_pslverr = 1'b0;
		if (!reg_hit)
		begin
			nxt_pslverr = 1'b1;
		end
		else if (sel_base_class)
		begin
			nxt_prdata[7:0] = hbc_pkg::BASE_CLASS_VALUE;
		end
		else if (sel_latency_stub)
		begin
			nxt_prdata[7:0] = hbc_pkg::LATENCY_STUB_VALUE;
		end
		else if (sel_header_type)
		begin
			nxt_prdata[7:0] = hbc_pkg::HEADER_TYPE_VALUE;
		end
		else if (sel_subsys_vendor)
		begin
			nxt_prdata[15:0] = subsys_vendor_ff;
		end
		else if (sel_subsys)
		begin
			nxt_prdata[15:0] = subsys_ff;
		end
		else if (sel_cap_pointer)
		begin
			nxt_prdata[7:0] = hbc_pkg::CAP_POINTER_VALUE;
		end
		else
		begin
			nxt_prdata[7:0] = bridge_config_ff;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			prdata_ff <= 32'h00000000;
			pslverr_ff <= 1'b0;
		end
		else if (setup_phase && PWRITE)
		begin
			// Writes return zero so stale data never looks like a result
			prdata_ff <= 32'h00000000;
			pslverr_ff <= nxt_pslverr;
		end
		else if (setup_phase)
		begin
			prdata_ff <= nxt_prdata;
			pslverr_ff <= nxt_pslverr;
		end
	end

	// Write once: the first write access locks, even one with no byte lanes
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			subsys_vendor_ff <= hbc_pkg::SUBSYS_VENDOR_RESET;
			subsys_vendor_locked_ff <= 1'b0;
		end
		else if (vendor_write)
		begin
			subsys_vendor_ff <= merge16(subsys_vendor_ff, PWDATA, PSTRB);
			subsys_vendor_locked_ff <= 1'b1;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			subsys_ff <= hbc_pkg::SUBSYS_RESET;
			subsys_locked_ff <= 1'b0;
		end
		else if (subsys_write)
		begin
			subsys_ff <= merge16(subsys_ff, PWDATA, PSTRB);
			subsys_locked_ff <= 1'b1;
		end
	end

	// Reserved bits keep their reset value through the write mask
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			bridge_config_ff <= hbc_pkg::BRIDGE_CONFIG_RESET;
		end
		else if (config_write)
		begin
			bridge_config_ff <= merge_masked(bridge_config_ff, PWDATA[7:0],
				hbc_pkg::BRIDGE_CONFIG_WMASK);
		end
	end

	// Stall clocks saturate so a long stall never wraps back below the limit
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			stall_count_ff <= 5'h00;
		end
		else if (!DEFERRABLE_PENDING || defer_ff)
		begin
			stall_count_ff <= 5'h00;
		end
		else if (SNOOP_STALL && !stall_at_limit)
		begin
			stall_count_ff <= stall_count_ff + 5'h01;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			defer_ff <= 1'b0;
		end
		// A lone strobe with nothing pending defers nothing
		else if (defer_ff || !DEFERRABLE_PENDING || !HOST_ADDRESS_STROBE)
		begin
			defer_ff <= 1'b0;
		end
		else if (cfg.defer_latency_select)
		begin
			defer_ff <= stall_at_limit;
		end
		else
		begin
			defer_ff <= 1'b1;
		end
	end

	// D segment routing; cycles outside it are left to the outer decoder
	always_comb
	begin
		nxt_route_hub = 1'b0;
		nxt_route_dram = 1'b0;
		if (in_d_seg)
		begin
			if (cfg.d8_hole_forward_enable && in_d8_hole)
			begin
				nxt_route_hub = 1'b1;
			end
			else if (cfg.cd_hole_forward_enable && in_cd_hole)
			begin
				nxt_route_hub = 1'b1;
			end
			else
			begin
				nxt_route_dram = host_to_dram;
				nxt_route_hub = !host_to_dram;
			end
		end
	end

	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			route_hub_ff <= 1'b0;
			route_dram_ff <= 1'b0;
		end
		else
		begin
			route_hub_ff <= nxt_route_hub;
			route_dram_ff <= nxt_route_dram;
		end
	end

endmodule : hbc_config_regs

// file: testbench/hbc_checker.sv
`timescale 1ns/1ps
module hbc_checker
(
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic DEFERRABLE_PENDING,
	input wire logic HOST_ADDRESS_STROBE,
	input wire logic DEFER_CYCLE,
	input wire logic HOST_CYCLE_VALID,
	input wire logic [31:0] HOST_CYCLE_ADDR,
	input wire logic ROUTE_IO_HUB,
	input wire logic ROUTE_DRAM,
	input wire logic LOCAL_MEM_FREQ_133
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RESET_N);
	logic rd;
	logic dseg;
	assign rd = PSEL && PENABLE && !PWRITE;
	assign dseg = HOST_CYCLE_VALID && HOST_CYCLE_ADDR[31:16] == 16'h000d;
	property p_base; rd && PADDR == 12'h02c |-> PRDATA[7:0] == 8'h06; endproperty
	a_base: assert property (p_base) else $error("base class wrong");
	property p_lat; rd && PADDR == 12'h034 |-> PRDATA[7:0] == 8'h00; endproperty
	a_lat: assert property (p_lat) else $error("latency not zero");
	property p_hdr; rd && PADDR == 12'h038 |-> PRDATA[7:0] == 8'h00; endproperty
	a_hdr: assert property (p_hdr) else $error("header not zero");
	property p_cap; rd && PADDR == 12'h0d0 |-> PRDATA[7:0] == 8'h00; endproperty
	a_cap: assert property (p_cap) else $error("cap pointer not zero");
	property p_rsv; rd && PADDR == 12'h140 |-> PRDATA[7:5] ==? 3'b0?1 && !PRDATA[2]; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits changed");
	property p_dfr; DEFER_CYCLE |-> $past(HOST_ADDRESS_STROBE && DEFERRABLE_PENDING); endproperty
	a_dfr: assert property (p_dfr) else $error("defer without strobe");
	property p_dbl; DEFER_CYCLE |=> !DEFER_CYCLE; endproperty
	a_dbl: assert property (p_dbl) else $error("defer twice");
	property p_one; dseg |=> ROUTE_IO_HUB != ROUTE_DRAM; endproperty
	a_one: assert property (p_one) else $error("route not exclusive");
	property p_out; HOST_CYCLE_VALID && !dseg |=> !ROUTE_IO_HUB && !ROUTE_DRAM; endproperty
	a_out: assert property (p_out) else $error("route outside segment");
	property p_rst; $rose(RESET_N) |-> !LOCAL_MEM_FREQ_133; endproperty
	a_rst: assert property (p_rst) else $error("config not at reset");
	c_defer: cover property (DEFER_CYCLE);
	c_dram: cover property (ROUTE_DRAM);
	c_cfg: cover property (rd && PADDR == 12'h140);
endmodule : hbc_checker
bind hbc_config_regs hbc_checker i_hbc_checker (.CLK, .RESET_N, .PSEL, .PENABLE, .PWRITE,
	.PADDR, .PRDATA, .DEFERRABLE_PENDING, .HOST_ADDRESS_STROBE, .DEFER_CYCLE,
	.HOST_CYCLE_VALID, .HOST_CYCLE_ADDR, .ROUTE_IO_HUB, .ROUTE_DRAM, .LOCAL_MEM_FREQ_133);

// file: testbench/hbc_host_model.sv
`timescale 1ns/1ps
module hbc_host_model
(
	input wire logic CLK,
	input wire logic defer,
	output logic pending = 1'b0,
	output logic stall = 1'b0,
	output logic strobe = 1'b0
);
	// Stall n clocks, then one more strobe while still pending
	task automatic run(input int n, output logic seen);
		@(posedge CLK);
		pending <= 1'b1;
		stall <= 1'b1;
		repeat (n) @(posedge CLK);
		strobe <= 1'b1;
		@(posedge CLK);
		strobe <= 1'b0;
		pending <= 1'b0;
		stall <= 1'b0;
		#1 seen = defer;
	endtask : run
endmodule : hbc_host_model

// file: testbench/hbc_config_regs_bench.sv
`timescale 1ns/1ps
module hbc_config_regs_bench;
	logic CLK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
	logic HOST_CYCLE_VALID = 0, HOST_CYCLE_WRITE = 0, PREADY, PSLVERR, ROUTE_IO_HUB, ROUTE_DRAM;
	logic DEFERRABLE_PENDING, SNOOP_STALL, HOST_ADDRESS_STROBE, DEFER_CYCLE;
	logic LOCAL_MEM_FREQ_133, PAGE_MISS_PRECHARGE_ALL, e, s;
	logic [11:0] PADDR = 0;
	logic [31:0] PWDATA = 0, HOST_CYCLE_ADDR = 0, PRDATA, r;
	logic [7:0] LEGACY_SEGMENT_ATTRIBUTE_MAP = 0;
	logic [3:0] PSTRB = 4'hf;
	int err_count = 0, check_count = 0;
	always #25 CLK = ~CLK;
	hbc_config_regs i_hbc_config_regs (.CLK, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
		.PWDATA, .PSTRB, .PREADY, .PRDATA, .PSLVERR, .LEGACY_SEGMENT_ATTRIBUTE_MAP,
		.HOST_CYCLE_VALID, .HOST_CYCLE_WRITE, .HOST_CYCLE_ADDR, .ROUTE_IO_HUB, .ROUTE_DRAM,
		.DEFERRABLE_PENDING, .SNOOP_STALL, .HOST_ADDRESS_STROBE, .DEFER_CYCLE,
		.LOCAL_MEM_FREQ_133, .PAGE_MISS_PRECHARGE_ALL);
	hbc_host_model i_hbc_host_model (.CLK, .defer(DEFER_CYCLE), .pending(DEFERRABLE_PENDING),
		.stall(SNOOP_STALL), .strobe(HOST_ADDRESS_STROBE));
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		check_count++;
		if (g !== x)
		begin
			err_count++;
			$display("unexpected %s expected %h seen %h", n, x, g);
		end
	endtask : chk
	task automatic ap(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do @(posedge CLK); while (PREADY !== 1'b1);
		r = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : ap
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		ap(1'b0, a, 32'h0);
		chk("prdata", x, r);
	endtask : rd
	task automatic rt(input logic [7:0] m, input logic [31:0] a, input logic w, input logic [1:0] x);
		@(posedge CLK);
		LEGACY_SEGMENT_ATTRIBUTE_MAP <= m;
		HOST_CYCLE_VALID <= 1'b1;
		HOST_CYCLE_ADDR <= a;
		HOST_CYCLE_WRITE <= w;
		@(posedge CLK);
		#1 chk("route", {30'h0, x}, {30'h0, ROUTE_IO_HUB, ROUTE_DRAM});
	endtask : rt
	task automatic dfr(input int n, input logic x);
		i_hbc_host_model.run(n, s);
		chk("defer", {31'h0, x}, {31'h0, s});
	endtask : dfr
	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop
	initial
	begin
		#100000;
		err_count++;
		report_and_stop();
	end
	initial
	begin
		repeat (16) @(posedge CLK);
		RESET_N <= 1'b1;
		rd(12'h02c, 32'h06);
		rd(12'h034, 32'h00);
		rd(12'h038, 32'h00);
		rd(12'h0b0, 32'h0000);
		rd(12'h0b8, 32'h0000);
		rd(12'h0d0, 32'h00);
		rd(12'h140, 32'h60);
		ap(1'b0, 12'h004, 32'h0);
		chk("pslverr", 32'h1, {31'h0, e});
		ap(1'b1, 12'h02c, 32'hff);
		rd(12'h02c, 32'h06);
		ap(1'b1, 12'h0b0, 32'h1234);
		ap(1'b1, 12'h0b8, 32'habcd);
		ap(1'b1, 12'h0b0, 32'h5678);
		ap(1'b1, 12'h0b8, 32'h5678);
		rd(12'h0b0, 32'h1234);
		rd(12'h0b8, 32'habcd);
		$display("test registers done");
		ap(1'b1, 12'h140, 32'hff);
		rd(12'h140, 32'h7b);
		chk("freq", 32'h1, {31'h0, LOCAL_MEM_FREQ_133});
		chk("precharge", 32'h1, {31'h0, PAGE_MISS_PRECHARGE_ALL});
		rt(8'h0c, 32'h000d9000, 1'b0, 2'b10);
		rt(8'h0c, 32'h000dc000, 1'b1, 2'b10);
		rt(8'h0c, 32'h000d4000, 1'b0, 2'b01);
		rt(8'h0c, 32'h000e0000, 1'b0, 2'b00);
		dfr(30, 1'b0);
		dfr(31, 1'b1);
		ap(1'b1, 12'h140, 32'h01);
		#1;
		chk("freq", 32'h0, {31'h0, LOCAL_MEM_FREQ_133});
		chk("precharge", 32'h0, {31'h0, PAGE_MISS_PRECHARGE_ALL});
		dfr(0, 1'b1);
		rt(8'h0c, 32'h000d9000, 1'b0, 2'b01);
		rt(8'h0c, 32'h000dc000, 1'b0, 2'b10);
		ap(1'b1, 12'h140, 32'h00);
		rd(12'h140, 32'h20);
		for (int a = 0; a < 4; a++)
			for (int w = 0; w < 2; w++)
			begin
				rt({4'h0, a[1:0], 2'b00}, 32'h000d8000, w[0], a[w] ? 2'b01 : 2'b10);
				rt({4'h0, a[1:0], 2'b00}, 32'h000dffff, w[0], a[w] ? 2'b01 : 2'b10);
			end
		$display("test routing and deferral done");
		report_and_stop();
	end
endmodule : hbc_config_regs_bench
